// ---- shared/fpn_pkg.sv ----
// Constants and types of the front-panel page navigator
// How it works
// - Keys one+four open menu; two/three move; four enters
// - Meter keys two+three open tariff view
// - Key four steps voltage/current pages, wraps
// - Line wiring shows voltage pages three, four; page one after reset
// - Key two cycles power pages; line wiring five, six
// - Key one cycles angle/unbalance pages, wraps
// - Key three cycles energy/clock pages, wraps
// - Running time in hundredths of hour, clearable
// - Tariff view keys: tariff, demand steps, energy, type
// - Tariff view keys two+three return to metering
// - Statistics: key one idle, two next, three previous
// - Statistics key four toggles maximum/minimum
// - Line wiring drops first statistics page
// - Demand mode has two pages
// - Quality view: key one cycles, four to ratio
// - Ratio view: order steps two..highest, wraps
// - Ratio view: key one back, four volt/current
// - I/O mode opens on module page, banner if none
// - Module page: two/three move cursor, four enters
// - Items 3,3,3,4 per type; one back; four opens
// - Data pages: one back, two/three page, wraps
// - Dark backlight: first press only lights it
package fpn_pkg;

  // Timing
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned DEB_MS = 10;
  localparam int unsigned DEB_CYC = DEB_MS * CLK_KHZ;
  localparam int unsigned COMBO_MS = 50;
  localparam int unsigned COMBO_CYC = COMBO_MS * CLK_KHZ;
  localparam int unsigned RUN_STEP_MS = 36000;
  localparam logic [31:0] RUN_STEP_CYC = 32'(64'(RUN_STEP_MS) * 64'(CLK_KHZ));

  // Page widths and counts
  localparam int unsigned PW = 6;
  localparam int unsigned VA_PAGES = 5;
  localparam int unsigned PWR_PAGES = 6;
  localparam int unsigned ANG_PAGES = 2;
  localparam int unsigned EN_PAGES = 8;
  localparam int unsigned STAT_PAGES = 8;
  localparam int unsigned DMD_PAGES = 2;
  localparam int unsigned HPQ_PAGES = 4;
  localparam int unsigned TOU_TARIFFS = 4;
  localparam int unsigned TOU_TYPES = 3;
  localparam int unsigned MENU_ITEMS = 6;
  localparam int unsigned HARM_MAX_BASE = 31;
  localparam int unsigned HARM_MAX_EXT = 63;
  localparam logic [PW-1:0] HARM_MIN = 6'h02;
  localparam logic [PW-1:0] VA_LL_FIRST = 6'h02;
  localparam logic [PW-1:0] VA_LL_LAST = 6'h03;
  localparam logic [PW-1:0] PWR_LL_FIRST = 6'h04;
  localparam logic [PW-1:0] PWR_LL_LAST = 6'h05;
  localparam logic [PW-1:0] STAT_LL_FIRST = 6'h01;
  localparam logic [1:0] IO_ITEMS_SHORT_LAST = 2'h2;
  localparam logic [1:0] IO_ITEMS_LONG_LAST = 2'h3;
  localparam logic [1:0] IO_TYPE_LONG = 2'h3;

  // Key masks, bit 0 is the leftmost key
  localparam logic [3:0] KEY_1 = 4'h1;
  localparam logic [3:0] KEY_2 = 4'h2;
  localparam logic [3:0] KEY_3 = 4'h4;
  localparam logic [3:0] KEY_4 = 4'h8;
  localparam logic [3:0] KEY_14 = 4'h9;
  localparam logic [3:0] KEY_23 = 4'h6;

  // Menu cursor positions
  localparam logic [2:0] MENU_METER = 3'h0;
  localparam logic [2:0] MENU_STAT = 3'h1;
  localparam logic [2:0] MENU_DMD = 3'h2;
  localparam logic [2:0] MENU_HARM = 3'h3;
  localparam logic [2:0] MENU_SET = 3'h4;
  localparam logic [2:0] MENU_IO = 3'h5;

  typedef enum logic [9:0] {
    ST_MENU = 10'h001,
    ST_METER = 10'h002,
    ST_TOU = 10'h004,
    ST_STAT = 10'h008,
    ST_DMD = 10'h010,
    ST_HPQ = 10'h020,
    ST_HRATIO = 10'h040,
    ST_IOSEL = 10'h080,
    ST_IOITEM = 10'h100,
    ST_IODATA = 10'h200
  } fpn_state_t;

  typedef enum logic [3:0] {
    GRP_VA = 4'h1,
    GRP_PWR = 4'h2,
    GRP_ANG = 4'h4,
    GRP_EN = 4'h8
  } fpn_group_t;

  typedef enum logic [3:0] {
    TV_ENERGY = 4'h1,
    TV_DMD = 4'h2,
    TV_DATE = 4'h4,
    TV_TIME = 4'h8
  } fpn_tou_view_t;

  typedef enum logic [2:0] {
    KF_IDLE = 3'h1,
    KF_GATHER = 3'h2,
    KF_RELEASE = 3'h4
  } fpn_kf_state_t;

endpackage : fpn_pkg

// ---- core/fpn_key_filter.sv ----
// Key synchroniser, debouncer and combination gatherer
`timescale 1ns/1ps
module fpn_key_filter #(
  parameter int unsigned DEB_CYC = fpn_pkg::DEB_CYC,
  parameter int unsigned COMBO_CYC = fpn_pkg::COMBO_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Raw keys, high while pressed
  input wire logic [3:0] key_i,
  // Press event
  output logic ev_o,
  output logic [3:0] ev_mask_o
);

  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] stable;
  fpn_pkg::fpn_kf_state_t state;
  fpn_pkg::fpn_kf_state_t next_state;
  logic [31:0] win;
  logic [3:0] acc;
  wire win_done = (win >= COMBO_CYC - 1);

  always_ff @(posedge mclk_i) begin
    sync1 <= key_i;
    sync2 <= sync1;
  end

  ////////////////////////////////////////////////////////////////
  // Per-key debounce
  for (genvar k = 0; k < 4; k++) begin : g_deb
    logic [31:0] cnt;
    always_ff @(posedge mclk_i) begin
      if (srst_i || sync2[k] == stable[k]) begin
        cnt <= 32'h0;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        stable[k] <= 1'b0;
      end else if (sync2[k] != stable[k] && cnt >= DEB_CYC - 1) begin
        stable[k] <= sync2[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Combination window, one event
  always_comb begin
    next_state = state;
    case (state)
      fpn_pkg::KF_IDLE: if (stable != 4'h0) next_state = fpn_pkg::KF_GATHER;
      fpn_pkg::KF_GATHER: if (win_done) next_state = fpn_pkg::KF_RELEASE;
      fpn_pkg::KF_RELEASE: if (stable == 4'h0) next_state = fpn_pkg::KF_IDLE;
      default: next_state = fpn_pkg::KF_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= fpn_pkg::KF_IDLE;
      win <= 32'h0;
      acc <= 4'h0;
      ev_o <= 1'b0;
      ev_mask_o <= 4'h0;
    end else begin
      state <= next_state;
      win <= (state == fpn_pkg::KF_GATHER) ? win + 32'h1 : 32'h0;
      acc <= (state == fpn_pkg::KF_RELEASE) ? 4'h0 : acc | stable;
      ev_o <= (state == fpn_pkg::KF_GATHER) && win_done;
      if (state == fpn_pkg::KF_GATHER && win_done) begin
        ev_mask_o <= acc | stable;
      end
    end
  end

endmodule : fpn_key_filter

// ---- core/fpn_runtime.sv ----
// Running-time counter in hundredths of an hour
`timescale 1ns/1ps
module fpn_runtime #(
  parameter logic [31:0] STEP_CYC = fpn_pkg::RUN_STEP_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Restore and clear
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  // Total and store strobe
  output logic [31:0] hours_o,
  output logic save_o
);

  logic [31:0] cnt;
  wire step = (cnt >= STEP_CYC - 32'h1);

  ////////////////////////////////////////////////////////////////
  // Accumulate, restore, clear
  always_ff @(posedge mclk_i) begin
    if (srst_i || clear_i || step) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hours_o <= 32'h0;
      save_o <= 1'b0;
    end else begin
      save_o <= clear_i || (step && !load_i);
      if (clear_i) begin
        hours_o <= 32'h0;
      end else if (load_i) begin
        hours_o <= load_val_i;
      end else if (step) begin
        hours_o <= hours_o + 32'h1;
      end
    end
  end

endmodule : fpn_runtime

// ---- core/fpn_navigator.sv ----
// Front-panel page navigator top level
`timescale 1ns/1ps
module fpn_navigator #(
  parameter int unsigned DEB_CYC = fpn_pkg::DEB_CYC,
  parameter int unsigned COMBO_CYC = fpn_pkg::COMBO_CYC,
  parameter logic [31:0] RUN_STEP_CYC = fpn_pkg::RUN_STEP_CYC,
  parameter int unsigned HARM_MAX = fpn_pkg::HARM_MAX_BASE,
  parameter int unsigned VA_PAGES = fpn_pkg::VA_PAGES,
  parameter int unsigned PWR_PAGES = fpn_pkg::PWR_PAGES,
  parameter int unsigned ANG_PAGES = fpn_pkg::ANG_PAGES,
  parameter int unsigned EN_PAGES = fpn_pkg::EN_PAGES,
  parameter int unsigned STAT_PAGES = fpn_pkg::STAT_PAGES,
  parameter int unsigned HPQ_PAGES = fpn_pkg::HPQ_PAGES,
  parameter int unsigned TOU_TARIFFS = fpn_pkg::TOU_TARIFFS,
  parameter int unsigned TOU_TYPES = fpn_pkg::TOU_TYPES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Front-panel keys, high while pressed
  input wire logic [3:0] key_i,
  // Configuration and module status
  input wire logic line_wiring_i,
  input wire logic [2:0] io_count_i,
  input wire logic [1:0] io_type_i,
  input wire logic [5:0] io_pages_i,
  // Backlight
  input wire logic backlight_off_i,
  output logic backlight_on_o,
  // Running time
  input wire logic runtime_clear_i,
  input wire logic runtime_load_i,
  input wire logic [31:0] runtime_load_val_i,
  output logic [31:0] runtime_o,
  output logic runtime_save_o,
  // Page selection
  output fpn_pkg::fpn_state_t mode_o,
  output logic [2:0] menu_cursor_o,
  output fpn_pkg::fpn_group_t group_o,
  output logic [5:0] page_o,
  output logic stat_min_o,
  output logic [5:0] harm_order_o,
  output logic harm_current_o,
  output fpn_pkg::fpn_tou_view_t tou_view_o,
  output logic [1:0] tou_tariff_o,
  output logic [1:0] tou_type_o,
  output logic [2:0] io_module_o,
  output logic [1:0] io_item_o,
  output logic no_module_o,
  output logic setting_req_o
);

  localparam int unsigned PW = fpn_pkg::PW;

  ////////////////////////////////////////////////////////////////
  // Wrap helpers

  function automatic logic [PW-1:0] inc_wrap(
    input logic [PW-1:0] v,
    input logic [PW-1:0] lo,
    input logic [PW-1:0] hi
  );
    return (v >= hi || v < lo) ? lo : v + 6'h01;
  endfunction : inc_wrap

  function automatic logic [PW-1:0] dec_wrap(
    input logic [PW-1:0] v,
    input logic [PW-1:0] lo,
    input logic [PW-1:0] hi
  );
    return (v <= lo || v > hi) ? hi : v - 6'h01;
  endfunction : dec_wrap

  ////////////////////////////////////////////////////////////////
  // Key events

  logic kev;
  logic [3:0] kmask;

  fpn_key_filter #(
    .DEB_CYC(DEB_CYC),
    .COMBO_CYC(COMBO_CYC)
  ) u_keys (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .key_i(key_i),
    .ev_o(kev),
    .ev_mask_o(kmask)
  );

  fpn_runtime #(
    .STEP_CYC(RUN_STEP_CYC)
  ) u_runtime (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .clear_i(runtime_clear_i),
    .load_i(runtime_load_i),
    .load_val_i(runtime_load_val_i),
    .hours_o(runtime_o),
    .save_o(runtime_save_o)
  );

  logic bl;
  wire wake = kev && !bl;
  wire ev = kev && bl;
  wire k1 = ev && kmask == fpn_pkg::KEY_1;
  wire k2 = ev && kmask == fpn_pkg::KEY_2;
  wire k3 = ev && kmask == fpn_pkg::KEY_3;
  wire k4 = ev && kmask == fpn_pkg::KEY_4;
  wire c14 = ev && kmask == fpn_pkg::KEY_14;
  wire c23 = ev && kmask == fpn_pkg::KEY_23;

  ////////////////////////////////////////////////////////////////
  // Page ranges

  wire ll = line_wiring_i;
  wire [PW-1:0] va_lo = ll ? fpn_pkg::VA_LL_FIRST : 6'h00;
  wire [PW-1:0] va_hi = ll ? fpn_pkg::VA_LL_LAST : PW'(VA_PAGES - 1);
  wire [PW-1:0] pwr_lo = ll ? fpn_pkg::PWR_LL_FIRST : 6'h00;
  wire [PW-1:0] pwr_hi = ll ? fpn_pkg::PWR_LL_LAST : PW'(PWR_PAGES - 1);
  wire [PW-1:0] st_lo = ll ? fpn_pkg::STAT_LL_FIRST : 6'h00;
  wire [PW-1:0] st_hi = PW'(STAT_PAGES - 1);
  wire [PW-1:0] ang_hi = PW'(ANG_PAGES - 1);
  wire [PW-1:0] en_hi = PW'(EN_PAGES - 1);
  wire [PW-1:0] dmd_hi = PW'(fpn_pkg::DMD_PAGES - 1);
  wire [PW-1:0] hpq_hi = PW'(HPQ_PAGES - 1);
  wire [PW-1:0] hmax = PW'(HARM_MAX);
  wire [PW-1:0] menu_hi = PW'(fpn_pkg::MENU_ITEMS - 1);
  wire [PW-1:0] tar_hi = PW'(TOU_TARIFFS - 1);
  wire [PW-1:0] typ_hi = PW'(TOU_TYPES - 1);
  wire [PW-1:0] mod_hi = {3'h0, io_count_i - 3'h1};
  wire [PW-1:0] item_hi = {4'h0, (io_type_i == fpn_pkg::IO_TYPE_LONG) ?
                           fpn_pkg::IO_ITEMS_LONG_LAST : fpn_pkg::IO_ITEMS_SHORT_LAST};
  wire [PW-1:0] data_hi = io_pages_i - 6'h01;
  wire multi_mod = io_count_i > 3'h1;
  wire multi_page = io_pages_i > 6'h01;

  ////////////////////////////////////////////////////////////////
  // Navigation state

  fpn_pkg::fpn_state_t state;
  fpn_pkg::fpn_state_t next_state;
  fpn_pkg::fpn_group_t group;
  fpn_pkg::fpn_group_t next_group;
  fpn_pkg::fpn_tou_view_t tview;
  fpn_pkg::fpn_tou_view_t next_tview;
  logic [PW-1:0] cursor;
  logic [PW-1:0] next_cursor;
  logic [PW-1:0] page;
  logic [PW-1:0] next_page;
  logic [PW-1:0] horder;
  logic [PW-1:0] next_horder;
  logic [PW-1:0] ttar;
  logic [PW-1:0] next_ttar;
  logic [PW-1:0] ttype;
  logic [PW-1:0] next_ttype;
  logic [PW-1:0] iomod;
  logic [PW-1:0] next_iomod;
  logic [PW-1:0] ioitem;
  logic [PW-1:0] next_ioitem;
  logic smin;
  logic next_smin;
  logic hcur;
  logic next_hcur;
  logic setreq;
  logic next_setreq;

  always_comb begin
    next_state = state;
    next_group = group;
    next_tview = tview;
    next_cursor = cursor;
    next_page = page;
    next_horder = horder;
    next_ttar = ttar;
    next_ttype = ttype;
    next_iomod = iomod;
    next_ioitem = ioitem;
    next_smin = smin;
    next_hcur = hcur;
    next_setreq = 1'b0;
    case (state)
      fpn_pkg::ST_MENU: begin
        if (k2) begin
          next_cursor = inc_wrap(cursor, 6'h00, menu_hi);
        end else if (k3) begin
          next_cursor = dec_wrap(cursor, 6'h00, menu_hi);
        end else if (k4) begin
          next_smin = 1'b0;
          next_hcur = 1'b0;
          next_horder = fpn_pkg::HARM_MIN;
          next_iomod = 6'h00;
          next_ioitem = 6'h00;
          next_group = fpn_pkg::GRP_VA;
          case (cursor[2:0])
            fpn_pkg::MENU_METER: begin
              next_state = fpn_pkg::ST_METER;
              next_page = va_lo;
            end
            fpn_pkg::MENU_STAT: begin
              next_state = fpn_pkg::ST_STAT;
              next_page = st_lo;
            end
            fpn_pkg::MENU_DMD: begin
              next_state = fpn_pkg::ST_DMD;
              next_page = 6'h00;
            end
            fpn_pkg::MENU_HARM: begin
              next_state = fpn_pkg::ST_HPQ;
              next_page = 6'h00;
            end
            fpn_pkg::MENU_IO: begin
              next_state = fpn_pkg::ST_IOSEL;
              next_page = 6'h00;
            end
            default: next_setreq = 1'b1;
          endcase
        end
      end
      fpn_pkg::ST_METER: begin
        if (c23) begin
          next_state = fpn_pkg::ST_TOU;
          next_tview = fpn_pkg::TV_ENERGY;
          next_ttar = 6'h00;
          next_ttype = 6'h00;
        end else if (k4) begin
          next_group = fpn_pkg::GRP_VA;
          next_page = (group == fpn_pkg::GRP_VA) ? inc_wrap(page, va_lo, va_hi) : va_lo;
        end else if (k2) begin
          next_group = fpn_pkg::GRP_PWR;
          next_page = (group == fpn_pkg::GRP_PWR) ? inc_wrap(page, pwr_lo, pwr_hi) : pwr_lo;
        end else if (k1) begin
          next_group = fpn_pkg::GRP_ANG;
          next_page = (group == fpn_pkg::GRP_ANG) ? inc_wrap(page, 6'h00, ang_hi) : 6'h00;
        end else if (k3) begin
          next_group = fpn_pkg::GRP_EN;
          next_page = (group == fpn_pkg::GRP_EN) ? inc_wrap(page, 6'h00, en_hi) : 6'h00;
        end
      end
      fpn_pkg::ST_TOU: begin
        if (c23) begin
          next_state = fpn_pkg::ST_METER;
        end else if (k3) begin
          next_tview = fpn_pkg::TV_ENERGY;
        end else if (k2) begin
          case (tview)
            fpn_pkg::TV_DMD: next_tview = fpn_pkg::TV_DATE;
            fpn_pkg::TV_DATE: next_tview = fpn_pkg::TV_TIME;
            default: next_tview = fpn_pkg::TV_DMD;
          endcase
        end else if (k1) begin
          next_ttar = inc_wrap(ttar, 6'h00, tar_hi);
        end else if (k4) begin
          next_ttype = inc_wrap(ttype, 6'h00, typ_hi);
        end
      end
      fpn_pkg::ST_STAT: begin
        if (k2) begin
          next_page = inc_wrap(page, st_lo, st_hi);
        end else if (k3) begin
          next_page = dec_wrap(page, st_lo, st_hi);
        end else if (k4) begin
          next_smin = !smin;
        end
      end
      fpn_pkg::ST_DMD: begin
        if (k2) begin
          next_page = inc_wrap(page, 6'h00, dmd_hi);
        end else if (k3) begin
          next_page = dec_wrap(page, 6'h00, dmd_hi);
        end
      end
      fpn_pkg::ST_HPQ: begin
        if (k1) begin
          next_page = inc_wrap(page, 6'h00, hpq_hi);
        end else if (k4) begin
          next_state = fpn_pkg::ST_HRATIO;
        end
      end
      fpn_pkg::ST_HRATIO: begin
        if (k2) begin
          next_horder = inc_wrap(horder, fpn_pkg::HARM_MIN, hmax);
        end else if (k3) begin
          next_horder = dec_wrap(horder, fpn_pkg::HARM_MIN, hmax);
        end else if (k1) begin
          next_state = fpn_pkg::ST_HPQ;
        end else if (k4) begin
          next_hcur = !hcur;
        end
      end
      fpn_pkg::ST_IOSEL: begin
        if (k2 && multi_mod) begin
          next_iomod = inc_wrap(iomod, 6'h00, mod_hi);
        end else if (k3 && multi_mod) begin
          next_iomod = dec_wrap(iomod, 6'h00, mod_hi);
        end else if (k4 && io_count_i != 3'h0) begin
          next_state = fpn_pkg::ST_IOITEM;
          next_ioitem = 6'h00;
        end
      end
      fpn_pkg::ST_IOITEM: begin
        if (k1) begin
          next_state = fpn_pkg::ST_IOSEL;
        end else if (k2) begin
          next_ioitem = inc_wrap(ioitem, 6'h00, item_hi);
        end else if (k3) begin
          next_ioitem = dec_wrap(ioitem, 6'h00, item_hi);
        end else if (k4) begin
          next_state = fpn_pkg::ST_IODATA;
          next_page = 6'h00;
        end
      end
      fpn_pkg::ST_IODATA: begin
        if (k1) begin
          next_state = fpn_pkg::ST_IOITEM;
        end else if (k2 && multi_page) begin
          next_page = inc_wrap(page, 6'h00, data_hi);
        end else if (k3 && multi_page) begin
          next_page = dec_wrap(page, 6'h00, data_hi);
        end
      end
      default: next_state = fpn_pkg::ST_METER;
    endcase
    if (c14) begin
      next_state = fpn_pkg::ST_MENU;
      next_cursor = 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= fpn_pkg::ST_METER;
      group <= fpn_pkg::GRP_VA;
      tview <= fpn_pkg::TV_ENERGY;
      cursor <= 6'h00;
      page <= 6'h00;
      horder <= fpn_pkg::HARM_MIN;
    end else begin
      state <= next_state;
      group <= next_group;
      tview <= next_tview;
      cursor <= next_cursor;
      page <= next_page;
      horder <= next_horder;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ttar <= 6'h00;
      ttype <= 6'h00;
      iomod <= 6'h00;
      ioitem <= 6'h00;
      smin <= 1'b0;
      hcur <= 1'b0;
      setreq <= 1'b0;
      no_module_o <= 1'b0;
    end else begin
      ttar <= next_ttar;
      ttype <= next_ttype;
      iomod <= next_iomod;
      ioitem <= next_ioitem;
      smin <= next_smin;
      hcur <= next_hcur;
      setreq <= next_setreq;
      no_module_o <= (io_count_i == 3'h0);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bl <= 1'b1;
    end else begin
      bl <= wake || (bl && !backlight_off_i);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  assign backlight_on_o = bl;
  assign mode_o = state;
  assign menu_cursor_o = cursor[2:0];
  assign group_o = group;
  assign page_o = page;
  assign stat_min_o = smin;
  assign harm_order_o = horder;
  assign harm_current_o = hcur;
  assign tou_view_o = tview;
  assign tou_tariff_o = ttar[1:0];
  assign tou_type_o = ttype[1:0];
  assign io_module_o = iomod[2:0];
  assign io_item_o = ioitem[1:0];
  assign setting_req_o = setreq;

endmodule : fpn_navigator

// ---- test/fpn_checker.sv ----
// Port assertions for the page navigator
`timescale 1ns/1ps
module fpn_checker #(
  parameter int unsigned DEB_CYC = 4, COMBO_CYC = 8, HARM_MAX = 31
) (
  // Clock, reset and inputs
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] key_i,
  input wire logic line_wiring_i,
  input wire logic [2:0] io_count_i,
  input wire logic runtime_clear_i,
  input wire logic runtime_load_i,
  // Outputs
  input wire logic backlight_on_o,
  input wire logic [31:0] runtime_o,
  input wire logic runtime_save_o,
  input wire fpn_pkg::fpn_state_t mode_o,
  input wire fpn_pkg::fpn_group_t group_o,
  input wire logic [5:0] page_o,
  input wire logic [5:0] harm_order_o,
  input wire logic no_module_o,
  input wire logic setting_req_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  logic [31:0] idle;
  always_ff @(posedge mclk_i) begin
    idle <= (srst_i || key_i != 4'h0) ? 32'h0 : idle + 32'h1;
  end
  sequence quiet_run;
    (!runtime_clear_i && !runtime_load_i) [*3];
  endsequence
  sequence line_set;
    line_wiring_i [*3];
  endsequence
  ////////////////////////////////////////////////////////////////
  a_order_range: assert property (harm_order_o >= 6'h02 && harm_order_o <= 6'(HARM_MAX))
    else $error("order range");
  a_clear_zero: assert property (runtime_clear_i |=> ##[0:1] (runtime_o == 32'h0 && runtime_save_o))
    else $error("clear");
  a_step_one: assert property (quiet_run ##0 $changed(runtime_o) |-> runtime_o == $past(runtime_o) + 32'h1)
    else $error("step");
  a_wake_only: assert property ($changed(mode_o) || $changed(page_o) |-> $past(backlight_on_o))
    else $error("dark move");
  a_nomod_flag: assert property ((io_count_i == 3'h0) [*2] |-> no_module_o)
    else $error("no banner");
  a_setting_menu: assert property (setting_req_o |-> mode_o == fpn_pkg::ST_MENU)
    else $error("setting mode");
  a_line_va: assert property (line_set ##0 (mode_o == fpn_pkg::ST_METER && $stable(mode_o)
    && group_o == fpn_pkg::GRP_VA && $changed(page_o)) |-> page_o inside {6'h02, 6'h03})
    else $error("line page");
  a_stat_line: assert property (line_set ##0 (mode_o == fpn_pkg::ST_STAT && $stable(mode_o)
    && $changed(page_o)) |-> page_o != 6'h00)
    else $error("stat page");
  a_idle_still: assert property (idle > DEB_CYC + COMBO_CYC + 8 |-> $stable(mode_o) && $stable(page_o))
    else $error("idle move");
endmodule : fpn_checker
bind fpn_navigator fpn_checker #(.DEB_CYC(DEB_CYC), .COMBO_CYC(COMBO_CYC), .HARM_MAX(HARM_MAX))
  fpn_checker_inst (.*);

// ---- test/fpn_operator.sv ----
// Operator model pressing front-panel keys
`timescale 1ns/1ps
module fpn_operator #(
  parameter int HOLD = 24, REL = 14
) (
  // Clock and request
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [3:0] mask_i,
  // Keys and completion
  output logic [3:0] key_o,
  output logic done_o
);
  int cnt = 0;
  initial {key_o, done_o} = 5'h01;
  always @(posedge mclk_i) begin
    if (go_i) begin
      key_o <= mask_i;
      cnt <= 0;
      done_o <= 1'b0;
    end else if (!done_o) begin
      cnt <= cnt + 1;
      if (cnt == HOLD) key_o <= 4'h0;
      if (cnt == HOLD + REL) done_o <= 1'b1;
    end
  end
endmodule : fpn_operator

// ---- test/tb.sv ----
// Self-checking bench for the page navigator
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] K1 = 4'h1, K2 = 4'h2, K3 = 4'h4, K4 = 4'h8, K14 = 4'h9, K23 = 4'h6;
  localparam logic [5:0] NP = 6'h3F;
  localparam fpn_pkg::fpn_state_t ME = fpn_pkg::ST_METER, MN = fpn_pkg::ST_MENU;
  localparam fpn_pkg::fpn_state_t SA = fpn_pkg::ST_STAT, HQ = fpn_pkg::ST_HPQ;
  localparam fpn_pkg::fpn_state_t IS = fpn_pkg::ST_IOSEL, II = fpn_pkg::ST_IOITEM;
  localparam fpn_pkg::fpn_state_t TU = fpn_pkg::ST_TOU, HR = fpn_pkg::ST_HRATIO;
  localparam fpn_pkg::fpn_state_t DT = fpn_pkg::ST_IODATA, DM = fpn_pkg::ST_DMD;
  logic mclk_i = 1'b0, srst_i = 1'b1, line_wiring_i = 1'b0, backlight_off_i = 1'b0, go = 1'b0;
  logic runtime_clear_i = 1'b0, runtime_load_i = 1'b0;
  logic [2:0] io_count_i = 3'h0;
  logic [1:0] io_type_i = 2'h3;
  logic [5:0] io_pages_i = 6'h01;
  logic [31:0] runtime_load_val_i = 32'h0;
  logic [3:0] mask = 4'h0;
  logic done, backlight_on_o, runtime_save_o, stat_min_o, harm_current_o, no_module_o, setting_req_o;
  logic [3:0] key_i;
  logic [31:0] runtime_o;
  fpn_pkg::fpn_state_t mode_o;
  fpn_pkg::fpn_group_t group_o;
  fpn_pkg::fpn_tou_view_t tou_view_o;
  logic [5:0] page_o, harm_order_o;
  logic [2:0] menu_cursor_o, io_module_o;
  logic [1:0] tou_tariff_o, tou_type_o, io_item_o;
  int mismatches = 0, comparisons = 0;
  fpn_navigator #(.DEB_CYC(4), .COMBO_CYC(8), .RUN_STEP_CYC(32'h32)) fpn_navigator_inst (.*);
  fpn_operator fpn_operator_inst (.mclk_i(mclk_i), .go_i(go), .mask_i(mask), .key_o(key_i), .done_o(done));
  initial forever #5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task step(input logic [3:0] m, input fpn_pkg::fpn_state_t md, input logic [5:0] pg);
    @(posedge mclk_i);
    go <= 1'b1;
    mask <= m;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    repeat (99) if (done !== 1'b1) @(posedge mclk_i);
    chk(done, 32'h1);
    chk(mode_o, md);
    if (pg != NP) chk(page_o, pg);
  endtask : step
  task tally_and_finish;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  task s_meter;
    chk(backlight_on_o, 32'h1);
    for (int i = 1; i <= 5; i++) step(K4, ME, 6'(i % 5));
    for (int i = 0; i <= 2; i++) step(K1, ME, 6'(i % 2));
    for (int i = 0; i <= 8; i++) step(K3, ME, 6'(i % 8));
    for (int i = 0; i <= 6; i++) step(K2, ME, 6'(i % 6));
    chk(group_o, 32'h2);
  endtask : s_meter
  task s_tariff;
    logic [3:0] tv[4] = '{4'h2, 4'h4, 4'h8, 4'h2};
    step(K23, TU, NP);
    chk(tou_view_o, 32'h1);
    for (int i = 0; i < 4; i++) begin
      step(K2, TU, NP);
      chk(tou_view_o, tv[i]);
    end
    step(K1, TU, NP);
    step(K4, TU, NP);
    step(K3, TU, NP);
    chk({tou_tariff_o, tou_type_o, tou_view_o}, 32'h51);
    step(K23, ME, NP);
  endtask : s_tariff
  task s_stat(input logic [5:0] p0);
    step(K14, MN, NP);
    chk(menu_cursor_o, 32'h0);
    step(K2, MN, NP);
    step(K4, SA, p0);
    step(K3, SA, 6'h07);
    step(K2, SA, p0);
    step(K1, SA, p0);
    chk(stat_min_o, 32'h0);
    step(K4, SA, p0);
    chk(stat_min_o, 32'h1);
  endtask : s_stat
  task s_harm;
    step(K14, MN, NP);
    repeat (2) step(K2, MN, NP);
    step(K4, DM, 6'h00);
    step(K3, DM, 6'h01);
    step(K2, DM, 6'h00);
    step(K14, MN, NP);
    repeat (3) step(K2, MN, NP);
    step(K4, HQ, 6'h00);
    step(K1, HQ, 6'h01);
    step(K2, HQ, 6'h01);
    step(K4, HR, NP);
    step(K3, HR, NP);
    chk(harm_order_o, 32'd31);
    step(K2, HR, NP);
    chk(harm_order_o, 32'h2);
    step(K4, HR, NP);
    chk(harm_current_o, 32'h1);
    step(K1, HQ, NP);
  endtask : s_harm
  task s_wiring;
    line_wiring_i <= 1'b1;
    step(K14, MN, NP);
    step(K4, ME, NP);
    for (int i = 0; i < 3; i++) step(K2, ME, 6'(4 + i % 2));
    for (int i = 0; i < 3; i++) step(K4, ME, 6'(2 + i % 2));
    s_stat(6'h01);
    line_wiring_i <= 1'b0;
  endtask : s_wiring
  task s_io;
    step(K14, MN, NP);
    repeat (4) step(K2, MN, NP);
    step(K4, MN, NP);
    step(K2, MN, NP);
    step(K4, IS, NP);
    chk(no_module_o, 32'h1);
    step(K2, IS, NP);
    io_count_i <= 3'h1;
    step(K2, IS, NP);
    chk(io_module_o, 32'h0);
    io_count_i <= 3'h2;
    repeat (2) step(K2, IS, NP);
    step(K3, IS, NP);
    chk({no_module_o, io_module_o}, 32'h1);
    step(K4, II, NP);
    step(K3, II, NP);
    chk(io_item_o, 32'h3);
    step(K2, II, NP);
    chk(io_item_o, 32'h0);
    step(K4, DT, 6'h00);
    step(K2, DT, 6'h00);
    io_pages_i <= 6'h03;
    step(K3, DT, 6'h02);
    step(K4, DT, 6'h02);
    step(K1, II, NP);
    step(K1, IS, NP);
  endtask : s_io
  task s_dark_run;
    backlight_off_i <= 1'b1;
    @(posedge mclk_i);
    backlight_off_i <= 1'b0;
    step(K2, IS, NP);
    chk({backlight_on_o, io_module_o}, 32'h9);
    runtime_clear_i <= 1'b1;
    @(posedge mclk_i);
    runtime_clear_i <= 1'b0;
    runtime_load_i <= 1'b1;
    runtime_load_val_i <= 32'h10;
    @(posedge mclk_i);
    runtime_load_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(runtime_o, 32'h10);
    repeat (120) @(posedge mclk_i);
    chk(runtime_o, 32'h12);
  endtask : s_dark_run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    s_meter();
    s_tariff();
    s_stat(6'h00);
    s_harm();
    s_wiring();
    s_io();
    s_dark_run();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb
